// ===== verilog/sbc_bank_config_commit.sv
`timescale 1ns/1ps
module sbc_bank_config_commit import sbc_pkg::*; (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire sbc_cfg_req_t       cfg_in,
	output      sbc_cfg_resp_t      cfg_out,
	input  wire logic [15:0]        fn0_subsys_vendor,
	input  wire logic [15:0]        fn0_subsys_id,
	input  wire logic [1:0]         bank_stage_we,
	input  wire logic [1:0][31:0]   bank_stage_data,
	output      logic [1:0][31:0]   bank_fault,
	output      logic [1:0][31:0]   bank_live_cfg,
	output      logic [1:0][31:0]   bank_staged
);

	typedef struct packed {
		logic [31:0]      ctrl;
		sbc_cfg_resp_t    resp;
		logic [1:0][31:0] live;
		logic [1:0][31:0] staged;
	} sbc_top_state_t;

	sbc_top_state_t      s_reg;
	sbc_top_state_t      s_next;

	sbc_bank_cmd_t [1:0] bank_cmd;
	sbc_bank_evt_t [1:0] bank_evt;
	logic [1:0][31:0]    eng_staged;
	logic [1:0][31:0]    eng_committed;
	logic [1:0][31:0]    eng_fault;
	logic [1:0]          fault_we;
	logic [31:0]         lane_mask;
	logic [31:0]         read_word;
	logic                hit_subsys;
	logic                hit_ctrl;
	logic                hit_b1_fault;
	logic                wr_access;
	logic                rd_access;

	// Dword decode; the two subsystem halves share one dword
	assign hit_subsys   = cfg_in.addr[7:2] == SBC_OFF_SUBSYS[7:2];
	assign hit_ctrl     = cfg_in.addr[7:2] == SBC_OFF_CTRL[7:2];
	assign hit_b1_fault = cfg_in.addr[7:2] == SBC_OFF_B1_FAULT[7:2];
	assign wr_access    = cfg_in.req && cfg_in.we;
	assign rd_access    = cfg_in.req && !cfg_in.we;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{cfg_in.be[i]}};
		end
	end

	// Bank 0 fault has no address of its own; only bank 1 is writable here
	assign fault_we[0] = 1'b0;
	assign fault_we[1] = wr_access && hit_b1_fault && (cfg_in.be != 4'h0);

	always_comb begin
		read_word = '0;
		if (hit_subsys) begin
			read_word[SBC_VENDOR_LSB +: 16] = fn0_subsys_vendor;
			read_word[SBC_ID_LSB +: 16]     = fn0_subsys_id;
		end else if (hit_ctrl) begin
			read_word = s_reg.ctrl & SBC_CTRL_WMASK;
		end else if (hit_b1_fault) begin
			read_word = eng_fault[1];
		end
	end

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bank
			assign bank_cmd[b].enable   = s_reg.ctrl[b*SBC_BANK_STRIDE + SBC_BIT_ENABLE];
			assign bank_cmd[b].check    = s_reg.ctrl[b*SBC_BANK_STRIDE + SBC_BIT_CHECK];
			assign bank_cmd[b].commit   = s_reg.ctrl[b*SBC_BANK_STRIDE + SBC_BIT_COMMIT];
			assign bank_cmd[b].rollback = s_reg.ctrl[b*SBC_BANK_STRIDE + SBC_BIT_ROLLBACK];

			sbc_bank_engine u_engine (
				.clock         (clock),
				.sys_rst       (sys_rst),
				.cmd           (bank_cmd[b]),
				.stage_we      (bank_stage_we[b]),
				.stage_data    (bank_stage_data[b]),
				.fault_we      (fault_we[b]),
				.fault_wdata   ((eng_fault[b] & ~lane_mask) | (cfg_in.wdata & lane_mask)),
				.staged_cfg    (eng_staged[b]),
				.committed_cfg (eng_committed[b]),
				.fault_code    (eng_fault[b]),
				.evt           (bank_evt[b])
			);
		end
	endgenerate

	always_comb begin
		s_next          = s_reg;
		s_next.resp.ack = cfg_in.req;
		if (rd_access) begin
			s_next.resp.rdata = read_word;
		end

		// Finished commands drop their own bits
		for (int i = 0; i < 2; i++) begin
			if (bank_evt[i].done) begin
				s_next.ctrl = s_next.ctrl & ~(SBC_BANK_CMD_MASK << (i*SBC_BANK_STRIDE));
			end
			if (bank_evt[i].clr_enable) begin
				s_next.ctrl[i*SBC_BANK_STRIDE + SBC_BIT_ENABLE] = 1'b0;
			end
		end

		// A software write in the same cycle as a finish re-arms the command
		if (wr_access && hit_ctrl) begin
			s_next.ctrl = ((s_next.ctrl & ~lane_mask) | (cfg_in.wdata & lane_mask)) & SBC_CTRL_WMASK;
		end

		// Hardware set wins over any clear in the same cycle
		for (int i = 0; i < 2; i++) begin
			if (bank_evt[i].set_enable) begin
				s_next.ctrl[i*SBC_BANK_STRIDE + SBC_BIT_ENABLE] = 1'b1;
			end
		end

		// Committed settings are sticky; the enable bit only gates them
		for (int i = 0; i < 2; i++) begin
			if (s_reg.ctrl[i*SBC_BANK_STRIDE + SBC_BIT_ENABLE]) begin
				s_next.live[i] = eng_committed[i];
			end else begin
				s_next.live[i] = SBC_CFG_EMPTY;
			end
			s_next.staged[i] = eng_staged[i];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_reg.ctrl   <= SBC_CTRL_RESET;
			s_reg.resp   <= '0;
			s_reg.live   <= '0;
			s_reg.staged <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cfg_out       = s_reg.resp;
	assign bank_live_cfg = s_reg.live;
	assign bank_staged   = s_reg.staged;
	assign bank_fault    = eng_fault;

endmodule // sbc_bank_config_commit

// ===== verilog/sbc_pkg.sv
package sbc_pkg;

	// Configuration dword offsets (byte addresses)
	localparam logic [7:0]  SBC_OFF_SUBSYS      = 8'h2c;
	localparam logic [7:0]  SBC_OFF_SUBSYS_ID   = 8'h2e;
	localparam logic [7:0]  SBC_OFF_CTRL        = 8'h40;
	localparam logic [7:0]  SBC_OFF_B1_FAULT    = 8'hf8;

	// Halves of the subsystem dword
	localparam int          SBC_VENDOR_LSB      = 0;
	localparam int          SBC_ID_LSB          = 16;

	// Control register layout: bank b field starts at b * SBC_BANK_STRIDE
	localparam int          SBC_BANK_STRIDE     = 8;
	localparam int          SBC_BIT_ENABLE      = 0;
	localparam int          SBC_BIT_CHECK       = 1;
	localparam int          SBC_BIT_COMMIT      = 2;
	localparam int          SBC_BIT_ROLLBACK    = 3;
	localparam logic [31:0] SBC_CTRL_RESET      = 32'h0000_0000;
	localparam logic [31:0] SBC_CTRL_WMASK      = 32'h0000_0f0f;
	localparam logic [31:0] SBC_BANK_CMD_MASK   = 32'h0000_000e;

	// Sanity check on the staged bank word
	localparam int          SBC_ROW_MSB         = 31;
	localparam int          SBC_ROW_LSB         = 28;
	localparam int          SBC_COL_MSB         = 3;
	localparam int          SBC_COL_LSB         = 0;
	localparam logic [31:0] SBC_FAULT_NONE      = 32'h0000_0000;
	localparam logic [31:0] SBC_FAULT_ROWS      = 32'h0000_0001;
	localparam logic [31:0] SBC_FAULT_COLS      = 32'h0000_0002;
	localparam logic [31:0] SBC_CFG_EMPTY       = 32'h0000_0000;
	localparam logic [31:0] SBC_FAULT_RESET     = 32'h0000_0000;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} sbc_cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} sbc_cfg_resp_t;

	typedef struct packed {
		logic enable;
		logic check;
		logic commit;
		logic rollback;
	} sbc_bank_cmd_t;

	typedef struct packed {
		logic set_enable;
		logic clr_enable;
		logic done;
	} sbc_bank_evt_t;

endpackage

// ===== verilog/sbc_bank_engine.sv
`timescale 1ns/1ps
module sbc_bank_engine import sbc_pkg::*; (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire sbc_bank_cmd_t cmd,
	input  wire logic          stage_we,
	input  wire logic [31:0]   stage_data,
	input  wire logic          fault_we,
	input  wire logic [31:0]   fault_wdata,
	output      logic [31:0]   staged_cfg,
	output      logic [31:0]   committed_cfg,
	output      logic [31:0]   fault_code,
	output      sbc_bank_evt_t evt
);

	typedef struct packed {
		logic [31:0] staged;
		logic [31:0] committed;
		logic [31:0] fault;
	} sbc_eng_state_t;

	sbc_eng_state_t s_reg;
	sbc_eng_state_t s_next;
	logic [31:0]    chk_result;

	always_comb begin
		if (s_reg.staged[SBC_ROW_MSB:SBC_ROW_LSB] == '0) begin
			chk_result = SBC_FAULT_ROWS;
		end else if (s_reg.staged[SBC_COL_MSB:SBC_COL_LSB] == '0) begin
			chk_result = SBC_FAULT_COLS;
		end else begin
			chk_result = SBC_FAULT_NONE;
		end
	end

	always_comb begin
		s_next = s_reg;
		evt    = '0;
		// Software staging first so a command in the same cycle takes precedence
		if (stage_we) begin
			s_next.staged = stage_data;
		end
		if (fault_we) begin
			s_next.fault = fault_wdata;
		end
		if (cmd.rollback) begin
			s_next.staged = s_reg.committed;
			evt.done      = 1'b1;
		end else if (cmd.commit) begin
			evt.done = 1'b1;
			if (!cmd.enable) begin
				// Bank stays empty; staged contents are kept untouched
				evt.clr_enable = 1'b0;
			end else begin
				s_next.fault = chk_result;
				if (chk_result == SBC_FAULT_NONE) begin
					s_next.committed = s_reg.staged;
					evt.set_enable   = 1'b1;
				end else begin
					evt.clr_enable = 1'b1;
				end
			end
		end else if (cmd.check) begin
			s_next.fault = chk_result;
			evt.done     = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_reg <= '{staged: SBC_CFG_EMPTY, committed: SBC_CFG_EMPTY, fault: SBC_FAULT_RESET};
		end else begin
			s_reg <= s_next;
		end
	end

	assign staged_cfg    = s_reg.staged;
	assign committed_cfg = s_reg.committed;
	assign fault_code    = s_reg.fault;

endmodule // sbc_bank_engine

// ===== sim/sbc_bank_config_commit_chk.sv
`timescale 1ns/1ps
module sbc_bank_config_commit_chk import sbc_pkg::*; (
	input wire logic             clock,
	input wire logic             sys_rst,
	input wire sbc_cfg_req_t     cfg_in,
	input wire sbc_cfg_resp_t    cfg_out,
	input wire logic [15:0]      fn0_subsys_vendor,
	input wire logic [15:0]      fn0_subsys_id,
	input wire logic [1:0]       bank_stage_we,
	input wire logic [1:0][31:0] bank_stage_data,
	input wire logic [1:0][31:0] bank_fault,
	input wire logic [1:0][31:0] bank_live_cfg,
	input wire logic [1:0][31:0] bank_staged
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire ctrl_wr = cfg_in.req && cfg_in.we && cfg_in.addr[7:2] == SBC_OFF_CTRL[7:2];
	sequence s_rd(logic [7:0] a);
		cfg_in.req && !cfg_in.we && cfg_in.addr[7:2] == a[7:2];
	endsequence
	property p_ack;
		cfg_out.ack == $past(cfg_in.req);
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	property p_vendor;
		s_rd(SBC_OFF_SUBSYS) |=> cfg_out.rdata[15:0] == $past(fn0_subsys_vendor);
	endproperty
	a_vendor: assert property (p_vendor) else $error("vendor mirror wrong");
	property p_id;
		s_rd(SBC_OFF_SUBSYS_ID) |=> cfg_out.rdata[31:16] == $past(fn0_subsys_id);
	endproperty
	a_id: assert property (p_id) else $error("subsystem mirror wrong");
	property p_rsvd;
		s_rd(SBC_OFF_CTRL) |=> cfg_out.rdata[31:12] == 20'h0 && cfg_out.rdata[7:4] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved control bits read nonzero");
	property p_f8;
		s_rd(SBC_OFF_B1_FAULT) |=> cfg_out.rdata == $past(bank_fault[1]);
	endproperty
	a_f8: assert property (p_f8) else $error("bank 1 fault read wrong");
	property p_fault0;
		$changed(bank_fault[0]) |-> $past(ctrl_wr, 2);
	endproperty
	a_fault0: assert property (p_fault0) else $error("bank 0 fault moved without command");
	property p_live;
		$changed(bank_live_cfg) |-> $past(ctrl_wr, 2) || $past(ctrl_wr, 3);
	endproperty
	a_live: assert property (p_live) else $error("live config moved without control write");
	property p_live_ok;
		bank_live_cfg[1] != 32'h0 |-> bank_live_cfg[1][31:28] != 4'h0 && bank_live_cfg[1][3:0] != 4'h0;
	endproperty
	a_live_ok: assert property (p_live_ok) else $error("failed config went live");
	property p_live_ok0;
		bank_live_cfg[0] != 32'h0 |-> bank_live_cfg[0][31:28] != 4'h0 && bank_live_cfg[0][3:0] != 4'h0;
	endproperty
	a_live_ok0: assert property (p_live_ok0) else $error("failed bank 0 config went live");
	property p_rst;
		$fell(sys_rst) |-> bank_live_cfg == '0 && bank_fault == '0 && bank_staged == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("state not clear after reset");
endmodule // sbc_bank_config_commit_chk
bind sbc_bank_config_commit sbc_bank_config_commit_chk u_chk (.clock(clock), .sys_rst(sys_rst),
	.cfg_in(cfg_in), .cfg_out(cfg_out), .fn0_subsys_vendor(fn0_subsys_vendor), .fn0_subsys_id(fn0_subsys_id),
	.bank_stage_we(bank_stage_we), .bank_stage_data(bank_stage_data), .bank_fault(bank_fault),
	.bank_live_cfg(bank_live_cfg), .bank_staged(bank_staged));

// ===== sim/test_sbc_bank_config_commit.sv
`timescale 1ns/1ps
module test_sbc_bank_config_commit import sbc_pkg::*;;
	logic             clock = 1'b0;
	logic             sys_rst = 1'b1;
	sbc_cfg_req_t     cin = '0;
	sbc_cfg_resp_t    cout;
	logic [15:0]      ven = '0;
	logic [15:0]      sub_id = '0;
	logic [1:0]       swe = '0;
	logic [1:0][31:0] sdat = '0;
	logic [1:0][31:0] flt;
	logic [1:0][31:0] live;
	logic [1:0][31:0] stg;
	logic [31:0]      rd;
	logic [31:0]      en = '0;
	logic [31:0]      d;
	logic [31:0]      com [2] = '{32'h0, 32'h0};
	int               b;
	int               failures = 0;
	int               n_tests = 0;
	int               seed = 91140;
	int               cyc = 0;
	sbc_bank_config_commit uut (.clock(clock), .sys_rst(sys_rst), .cfg_in(cin), .cfg_out(cout),
		.fn0_subsys_vendor(ven), .fn0_subsys_id(sub_id), .bank_stage_we(swe), .bank_stage_data(sdat),
		.bank_fault(flt), .bank_live_cfg(live), .bank_staged(stg));
	initial begin
		forever #2 clock = ~clock;
	end
	task automatic test_done;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole run is about 680 cycles; the watchdog fires at cycle 20000
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be = 4'hf);
		@(negedge clock);
		cin = '{1'b1, w, a, be, wd};
		@(negedge clock);
		cin.req = 1'b0;
		chk({31'h0, cout.ack}, 32'h1);
		rd = cout.rdata;
	endtask
	task automatic stage(input int k, input logic [31:0] v);
		@(negedge clock);
		swe[k] = 1'b1;
		sdat[k] = v;
		@(negedge clock);
		swe = '0;
	endtask
	// Enable bits of both banks ride along so the other bank is not disturbed
	task automatic cmd(input logic [3:0] c, input int k);
		acc(1'b1, SBC_OFF_CTRL, en | (32'(c) << (8 * k)));
		repeat (4) @(negedge clock);
	endtask
	task automatic look(input int k, input logic [31:0] f);
		acc(1'b0, SBC_OFF_CTRL, '0);
		chk(rd, en);
		chk(flt[k], f);
		chk(live[k], en[8 * k] ? com[k] : 32'h0);
	endtask
	function automatic logic [31:0] fcode(input logic [31:0] v);
		if (v[31:28] == 4'h0)
			return SBC_FAULT_ROWS;
		if (v[3:0] == 4'h0)
			return SBC_FAULT_COLS;
		return SBC_FAULT_NONE;
	endfunction
	initial begin
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		acc(1'b0, SBC_OFF_CTRL, '0);
		chk(rd, SBC_CTRL_RESET);
		acc(1'b1, SBC_OFF_CTRL, 32'hffff_f0f0);
		acc(1'b0, SBC_OFF_CTRL, '0);
		chk(rd, 32'h0);
		acc(1'b0, SBC_OFF_B1_FAULT, '0);
		chk(rd, SBC_FAULT_RESET);
		// Byte lanes: only the two low lanes of the fault word may move
		acc(1'b1, SBC_OFF_B1_FAULT, 32'h1234_5678, 4'h3);
		acc(1'b0, SBC_OFF_B1_FAULT, '0);
		chk(rd, 32'h0000_5678);
		chk(flt[1], 32'h0000_5678);
		acc(1'b1, SBC_OFF_CTRL, 32'h0000_0101, 4'h1);
		acc(1'b0, SBC_OFF_CTRL, '0);
		chk(rd, 32'h0000_0001);
		acc(1'b1, SBC_OFF_CTRL, 32'h0);
		// Unmapped dword: writes dropped, reads zero
		acc(1'b1, 8'h60, 32'hffff_ffff);
		acc(1'b0, 8'h60, '0);
		chk(rd, 32'h0);
		$display("test reset done");
		repeat (6) begin
			ven = 16'($random(seed));
			sub_id = 16'($random(seed));
			acc(1'b1, SBC_OFF_SUBSYS, $random(seed));
			acc(1'b0, SBC_OFF_SUBSYS, '0);
			chk(rd, {sub_id, ven});
		end
		$display("test mirror done");
		for (int i = 0; i < 12; i++) begin
			b = i % 2;
			d = $random(seed);
			if (i % 6 < 2)
				d[31:28] = 4'h0;
			else if (i % 6 < 4)
				d[3:0] = 4'h0;
			stage(b, d);
			en[8 * b] = 1'b1;
			cmd(4'h5, b);
			en[8 * b] = fcode(d) == SBC_FAULT_NONE;
			if (en[8 * b])
				com[b] = d;
			look(b, fcode(d));
			en[8 * b] = 1'b0;
			cmd(4'h0, b);
			look(b, fcode(d));
			cmd(4'h4, b);
			look(b, fcode(d));
			en[8 * b] = 1'b1;
			cmd(4'h0, b);
			look(b, fcode(d));
			d = $random(seed);
			stage(b, d);
			cmd(4'h2, b);
			look(b, fcode(d));
			cmd(4'he, b);
			look(b, fcode(d));
			chk(stg[b], com[b]);
			$display("test bank %0d round %0d done", b, i);
		end
		// Reset in mid-run must wipe committed and staged state
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		acc(1'b0, SBC_OFF_CTRL, '0);
		chk(rd, SBC_CTRL_RESET);
		for (int k = 0; k < 2; k++) begin
			chk(flt[k], SBC_FAULT_RESET);
			chk(live[k], SBC_CFG_EMPTY);
			chk(stg[k], SBC_CFG_EMPTY);
		end
		$display("test mid-run reset done");
		test_done;
	end
endmodule // test_sbc_bank_config_commit
